// ==== core/fpc_flash_ctl.sv ====
// What this block does
// - erase never covers less than one 512-byte page
// - eight sectors, each protectable against program/erase
// - state reads locked, first, second, unlocked codes
// - state reads 00_0100 while sector protect selected
// - busy codes for program, page and mass erase
// - page erase blanks every byte of selected page
// - page select hidden while sector protect selected
// - info select bit maps info area at top
// - page field drives flash address bits 15 to 9
// - any of 128 pages selectable as target
// - processor bus and debug port both program flash
// - option byte reloaded from flash on every reset
// - option changes act only after next reset
// - processor held in reset until options loaded
// - option configuration not reachable by software
// - options steer watchdog, protection, brownout, oscillator
// - user options come from flash byte 0000H
`timescale 1ns/10ps
`default_nettype none
module fpc_flash_ctl #(
	parameter int unsigned PROG_CYCLES = 16,
	parameter int unsigned PAGE_ERASE_CYCLES = 64,
	parameter int unsigned MASS_ERASE_CYCLES = 256,
	parameter int unsigned OPT_READ_CYCLES = 2
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite register slave
	input wire logic [fpc_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [fpc_pkg::DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [fpc_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [fpc_pkg::DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// debug port register writes
	input wire logic dbg_wr_valid,
	input wire logic [fpc_pkg::IDX_W-1:0] dbg_wr_index,
	input wire logic [fpc_pkg::DATA_W-1:0] dbg_wr_data,
	output logic dbg_wr_ready,
	// flash array
	output fpc_pkg::fpc_flash_req_s flash_req,
	input wire logic [7:0] flash_rdata,
	// reset sources and option configuration
	input wire logic stop_recover,
	output fpc_pkg::fpc_opt_s opt_cfg,
	output logic cpu_reset_n
);
	localparam logic [15:0] PROG_LOAD = 16'(PROG_CYCLES - 1);
	localparam logic [15:0] PERASE_LOAD = 16'(PAGE_ERASE_CYCLES - 1);
	localparam logic [15:0] MERASE_LOAD = 16'(MASS_ERASE_CYCLES - 1);
	localparam logic [7:0] OPT_LOAD = 8'(OPT_READ_CYCLES - 1);

	function automatic logic [5:0] state_code(input fpc_pkg::fpc_ctl_e s);
		unique case (s)
			fpc_pkg::C_LOCKED: state_code = fpc_pkg::ST_LOCKED;
			fpc_pkg::C_FIRST: state_code = fpc_pkg::ST_FIRST;
			fpc_pkg::C_SECOND: state_code = fpc_pkg::ST_SECOND;
			fpc_pkg::C_UNLOCKED: state_code = fpc_pkg::ST_UNLOCKED;
			fpc_pkg::C_SPR: state_code = fpc_pkg::ST_SPR;
			fpc_pkg::C_PROG: state_code = fpc_pkg::ST_PROG;
			fpc_pkg::C_PERASE: state_code = fpc_pkg::ST_PERASE;
			fpc_pkg::C_MERASE: state_code = fpc_pkg::ST_MERASE;
			default: state_code = fpc_pkg::ST_LOCKED;
		endcase
	endfunction

	function automatic logic mapped(input logic [fpc_pkg::IDX_W-1:0] idx);
		mapped = idx == fpc_pkg::IDX_CTL || idx == fpc_pkg::IDX_PAGE ||
			idx == fpc_pkg::IDX_PADDR || idx == fpc_pkg::IDX_PDATA;
	endfunction

	fpc_pkg::fpc_ctl_e state;
	fpc_pkg::fpc_ctl_e next_state;
	fpc_pkg::fpc_opt_e opt_state;
	fpc_pkg::fpc_page_s page_sel;
	logic [fpc_pkg::SECTORS-1:0] sect_prot;
	logic [fpc_pkg::PAGE_OFS_BITS-1:0] prog_ofs;
	logic [15:0] op_cnt;
	logic [7:0] opt_cnt;
	logic aw_held;
	logic w_held;
	logic [fpc_pkg::IDX_W-1:0] aw_idx;
	logic [fpc_pkg::DATA_W-1:0] w_data;
	logic w_lane0;
	logic bus_wr;
	logic wr_fire;
	logic [fpc_pkg::IDX_W-1:0] wr_idx;
	logic [fpc_pkg::DATA_W-1:0] wr_data;
	logic [7:0] wr_byte;
	logic is_ctl;
	logic is_page;
	logic busy;
	logic op_done;
	logic op_start;
	logic page_ok;
	logic mass_ok;
	logic [fpc_pkg::IDX_W-1:0] ar_idx;

	// axi write side: address and data are caught independently
	assign s_axi_awready = !aw_held;
	assign s_axi_wready = !w_held;
	assign bus_wr = aw_held && w_held && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			aw_idx <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held <= 1'b1;
			aw_idx <= s_axi_awaddr[fpc_pkg::ADDR_W-1:2];
		end else if (bus_wr) begin
			aw_held <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held <= 1'b0;
			w_data <= '0;
			w_lane0 <= 1'b0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held <= 1'b1;
			w_data <= s_axi_wdata;
			w_lane0 <= s_axi_wstrb[0];
		end else if (bus_wr) begin
			w_held <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= fpc_pkg::RESP_OKAY;
		end else if (bus_wr) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= mapped(aw_idx) ? fpc_pkg::RESP_OKAY : fpc_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// the bus wins a clash; the debug port simply waits one cycle
	assign dbg_wr_ready = !bus_wr;
	assign wr_fire = (bus_wr && w_lane0) || (dbg_wr_valid && !bus_wr);
	assign wr_idx = bus_wr ? aw_idx : dbg_wr_index;
	assign wr_data = bus_wr ? w_data : dbg_wr_data;
	assign wr_byte = wr_data[7:0];
	assign is_ctl = wr_fire && wr_idx == fpc_pkg::IDX_CTL;
	assign is_page = wr_fire && wr_idx == fpc_pkg::IDX_PAGE;

	// axi read side; option configuration has no index at all
	assign s_axi_arready = !s_axi_rvalid;
	assign ar_idx = s_axi_araddr[fpc_pkg::ADDR_W-1:2];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= fpc_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= mapped(ar_idx) ? fpc_pkg::RESP_OKAY : fpc_pkg::RESP_SLVERR;
			s_axi_rdata <= '0;
			if (ar_idx == fpc_pkg::IDX_CTL) begin
				s_axi_rdata[5:0] <= state_code(state);
			end else if (ar_idx == fpc_pkg::IDX_PAGE) begin
				s_axi_rdata[7:0] <= (state == fpc_pkg::C_SPR) ? sect_prot : page_sel;
			end else if (ar_idx == fpc_pkg::IDX_PADDR) begin
				s_axi_rdata[fpc_pkg::PAGE_OFS_BITS-1:0] <= prog_ofs;
			end
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// sixteen pages to a sector: the top three page bits pick the sector
	assign page_ok = !sect_prot[page_sel.page[6:4]] && opt_cfg.prog_prot_n;
	assign mass_ok = sect_prot == '0 && opt_cfg.prog_prot_n;
	assign busy = state == fpc_pkg::C_PROG || state == fpc_pkg::C_PERASE ||
		state == fpc_pkg::C_MERASE;
	assign op_done = busy && op_cnt == '0;

	always_comb begin
		next_state = state;
		unique case (state)
			fpc_pkg::C_LOCKED: begin
				if (is_ctl && wr_byte == fpc_pkg::CMD_UNLOCK1) begin
					next_state = fpc_pkg::C_FIRST;
				end
			end
			fpc_pkg::C_FIRST: begin
				if (is_ctl && wr_byte == fpc_pkg::CMD_UNLOCK2) begin
					next_state = fpc_pkg::C_SECOND;
				end else if (wr_fire) begin
					next_state = fpc_pkg::C_LOCKED;
				end
			end
			fpc_pkg::C_SECOND: begin
				if (is_page) begin
					next_state = fpc_pkg::C_UNLOCKED;
				end else if (wr_fire) begin
					next_state = fpc_pkg::C_LOCKED;
				end
			end
			fpc_pkg::C_UNLOCKED: begin
				if (is_ctl) begin
					if (wr_byte == fpc_pkg::CMD_SPR_SEL) begin
						next_state = fpc_pkg::C_SPR;
					end else if (wr_byte == fpc_pkg::CMD_PAGE_ERASE && page_ok) begin
						next_state = fpc_pkg::C_PERASE;
					end else if (wr_byte == fpc_pkg::CMD_MASS_ERASE && mass_ok) begin
						next_state = fpc_pkg::C_MERASE;
					end else begin
						next_state = fpc_pkg::C_LOCKED;
					end
				end else if (wr_fire && wr_idx == fpc_pkg::IDX_PDATA && page_ok) begin
					next_state = fpc_pkg::C_PROG;
				end
			end
			fpc_pkg::C_SPR: begin
				if (is_page) begin
					next_state = fpc_pkg::C_UNLOCKED;
				end else if (is_ctl) begin
					next_state = fpc_pkg::C_LOCKED;
				end
			end
			fpc_pkg::C_PROG: begin
				if (op_done) begin
					next_state = fpc_pkg::C_UNLOCKED;
				end
			end
			fpc_pkg::C_PERASE, fpc_pkg::C_MERASE: begin
				if (op_done) begin
					next_state = fpc_pkg::C_LOCKED;
				end
			end
			default: next_state = fpc_pkg::C_LOCKED;
		endcase
	end

	assign op_start = !busy && (next_state == fpc_pkg::C_PROG ||
		next_state == fpc_pkg::C_PERASE || next_state == fpc_pkg::C_MERASE);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= fpc_pkg::C_LOCKED;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			op_cnt <= '0;
		end else if (op_start) begin
			unique case (next_state)
				fpc_pkg::C_PROG: op_cnt <= PROG_LOAD;
				fpc_pkg::C_PERASE: op_cnt <= PERASE_LOAD;
				default: op_cnt <= MERASE_LOAD;
			endcase
		end else if (busy && op_cnt != '0) begin
			op_cnt <= op_cnt - 16'h0001;
		end
	end

	// page select is frozen while an operation runs
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			page_sel <= fpc_pkg::PAGE_SEL_RESET;
			sect_prot <= fpc_pkg::SPR_RESET;
		end else if (is_page && state == fpc_pkg::C_SPR) begin
			sect_prot <= sect_prot | wr_byte;
		end else if (is_page && !busy) begin
			page_sel <= wr_byte;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prog_ofs <= '0;
		end else if (wr_fire && !busy && wr_idx == fpc_pkg::IDX_PADDR) begin
			prog_ofs <= wr_data[fpc_pkg::PAGE_OFS_BITS-1:0];
		end
	end

	// one strobe per operation; the array times the pulse itself
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flash_req <= '0;
		end else begin
			flash_req.rd <= opt_state == fpc_pkg::O_FETCH;
			flash_req.prog <= op_start && next_state == fpc_pkg::C_PROG;
			flash_req.page_erase <= op_start && next_state == fpc_pkg::C_PERASE;
			flash_req.mass_erase <= op_start && next_state == fpc_pkg::C_MERASE;
			if (opt_state == fpc_pkg::O_FETCH) begin
				flash_req.addr <= fpc_pkg::OPT_ADDR;
				flash_req.info_sel <= 1'b0;
			end else if (op_start) begin
				flash_req.info_sel <= page_sel.info_sel;
				flash_req.addr <= {page_sel.page, next_state == fpc_pkg::C_PROG ?
					prog_ofs : fpc_pkg::PAGE_OFS_BITS'(0)};
				flash_req.wdata <= wr_byte;
			end
		end
	end

	// option load runs after every reset and every stop-mode recovery
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			opt_state <= fpc_pkg::O_FETCH;
			opt_cnt <= '0;
			opt_cfg <= fpc_pkg::OPT_RESET;
			cpu_reset_n <= 1'b0;
		end else begin
			unique case (opt_state)
				fpc_pkg::O_FETCH: begin
					opt_state <= fpc_pkg::O_WAIT;
					opt_cnt <= OPT_LOAD;
				end
				fpc_pkg::O_WAIT: begin
					if (opt_cnt == '0) begin
						opt_state <= fpc_pkg::O_DONE;
						opt_cfg <= flash_rdata;
						cpu_reset_n <= 1'b1;
					end else begin
						opt_cnt <= opt_cnt - 8'h01;
					end
				end
				fpc_pkg::O_DONE: begin
					if (stop_recover) begin
						opt_state <= fpc_pkg::O_FETCH;
						cpu_reset_n <= 1'b0;
					end
				end
			endcase
		end
	end

	sequence s_unlock1;
		is_ctl && wr_byte == fpc_pkg::CMD_UNLOCK1 && state == fpc_pkg::C_LOCKED;
	endsequence
	sequence s_unlock2;
		is_ctl && wr_byte == fpc_pkg::CMD_UNLOCK2 && state == fpc_pkg::C_FIRST;
	endsequence

	// the two commands lie many cycles apart on the bus, so each step is checked alone
	chk_unlock_first: assert property (@(posedge aclk) disable iff (!aresetn)
		s_unlock1 |=> state_code(state) == fpc_pkg::ST_FIRST)
		else $error("first unlock did not reach the first-unlock code");
	chk_unlock_steps: assert property (@(posedge aclk) disable iff (!aresetn)
		s_unlock2 |=> state_code(state) == fpc_pkg::ST_SECOND)
		else $error("second unlock did not reach the second-unlock code");
	chk_bad_order: assert property (@(posedge aclk) disable iff (!aresetn)
		state == fpc_pkg::C_FIRST && wr_fire && !(is_ctl && wr_byte == fpc_pkg::CMD_UNLOCK2)
		|=> state == fpc_pkg::C_LOCKED)
		else $error("wrong second write did not relock");
	chk_spr_read: assert property (@(posedge aclk) disable iff (!aresetn)
		state == fpc_pkg::C_SPR && s_axi_arvalid && s_axi_arready && ar_idx == fpc_pkg::IDX_PAGE
		|=> s_axi_rvalid && s_axi_rdata[7:0] == $past(sect_prot))
		else $error("shared address did not show sector protection");
	chk_erase_code: assert property (@(posedge aclk) disable iff (!aresetn)
		flash_req.page_erase |-> state_code(state) == fpc_pkg::ST_PERASE && op_cnt == PERASE_LOAD)
		else $error("page erase strobe without page erase code");
	chk_page_addr: assert property (@(posedge aclk) disable iff (!aresetn)
		flash_req.page_erase |-> flash_req.addr == {page_sel.page, fpc_pkg::PAGE_OFS_BITS'(0)})
		else $error("page erase address is not the whole selected page");
	chk_sector_guard: assert property (@(posedge aclk) disable iff (!aresetn)
		flash_req.prog || flash_req.page_erase |-> !sect_prot[flash_req.addr[15:13]])
		else $error("operation issued into a protected sector");
	chk_info_map: assert property (@(posedge aclk) disable iff (!aresetn)
		flash_req.prog || flash_req.page_erase |-> flash_req.info_sel == page_sel.info_sel)
		else $error("info area select not passed to the array");
	chk_opt_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		opt_state == fpc_pkg::O_DONE && !stop_recover |=> $stable(opt_cfg) && cpu_reset_n)
		else $error("option configuration changed without reset");
	chk_cpu_release: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(cpu_reset_n) |-> opt_state == fpc_pkg::O_DONE && opt_cfg == $past(flash_rdata))
		else $error("processor released before options were loaded");
	chk_opt_fetch: assert property (@(posedge aclk) disable iff (!aresetn)
		flash_req.rd |-> flash_req.addr == fpc_pkg::OPT_ADDR && !cpu_reset_n)
		else $error("option fetch not from the option byte address");
endmodule
`default_nettype wire

// ==== core/fpc_pkg.sv ====
package fpc_pkg;
	localparam int unsigned ADDR_W = 16;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned IDX_W = 14;
	// register index; byte address is four times the index
	localparam logic [13:0] IDX_CTL = 14'h0ff8;
	localparam logic [13:0] IDX_PAGE = 14'h0ff9;
	localparam logic [13:0] IDX_PADDR = 14'h0ffc;
	localparam logic [13:0] IDX_PDATA = 14'h0ffd;
	// command bytes written to the control register
	localparam logic [7:0] CMD_UNLOCK1 = 8'h73;
	localparam logic [7:0] CMD_UNLOCK2 = 8'h8c;
	localparam logic [7:0] CMD_SPR_SEL = 8'h5e;
	localparam logic [7:0] CMD_PAGE_ERASE = 8'h95;
	localparam logic [7:0] CMD_MASS_ERASE = 8'h63;
	// controller state codes as read back
	localparam logic [5:0] ST_LOCKED = 6'h00;
	localparam logic [5:0] ST_FIRST = 6'h01;
	localparam logic [5:0] ST_SECOND = 6'h02;
	localparam logic [5:0] ST_UNLOCKED = 6'h03;
	localparam logic [5:0] ST_SPR = 6'h04;
	localparam logic [5:0] ST_PROG = 6'h08;
	localparam logic [5:0] ST_PERASE = 6'h10;
	localparam logic [5:0] ST_MERASE = 6'h20;
	localparam int unsigned PAGE_BITS = 7;
	localparam int unsigned PAGE_OFS_BITS = 9;
	localparam int unsigned SECTORS = 8;
	localparam logic [15:0] OPT_ADDR = 16'h0000;
	localparam logic [7:0] PAGE_SEL_RESET = 8'h00;
	localparam logic [7:0] SPR_RESET = 8'h00;
	localparam logic [7:0] OPT_RESET = 8'hff;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [7:0] {
		C_LOCKED = 8'b0000_0001,
		C_FIRST = 8'b0000_0010,
		C_SECOND = 8'b0000_0100,
		C_UNLOCKED = 8'b0000_1000,
		C_SPR = 8'b0001_0000,
		C_PROG = 8'b0010_0000,
		C_PERASE = 8'b0100_0000,
		C_MERASE = 8'b1000_0000
	} fpc_ctl_e;

	typedef enum logic [2:0] {
		O_FETCH = 3'b001,
		O_WAIT = 3'b010,
		O_DONE = 3'b100
	} fpc_opt_e;

	typedef struct packed {
		logic info_sel;
		logic [6:0] page;
	} fpc_page_s;

	typedef struct packed {
		logic wdt_irq_mode;
		logic wdt_at_reset;
		logic read_prot_n;
		logic prog_prot_n;
		logic vbo_stop_on;
		logic rsvd;
		logic [1:0] osc_mode;
	} fpc_opt_s;

	typedef struct packed {
		logic rd;
		logic prog;
		logic page_erase;
		logic mass_erase;
		logic info_sel;
		logic [15:0] addr;
		logic [7:0] wdata;
	} fpc_flash_req_s;
endpackage

// ==== testbench/fpc_flash_ctl_test.sv ====
`timescale 1ns/10ps
`default_nettype none
module fpc_flash_ctl_test;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [15:0] s_axi_awaddr = 16'h0000;
	logic [15:0] s_axi_araddr = 16'h0000;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic [31:0] dbg_wr_data = 32'h0000_0000;
	logic [13:0] dbg_wr_index = 14'h0000;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, dbg_wr_valid = 1'b0, stop_recover = 1'b0;
	logic [7:0] flash_rdata = 8'h5a;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic dbg_wr_ready, cpu_reset_n;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata, rd_word;
	fpc_pkg::fpc_flash_req_s flash_req;
	fpc_pkg::fpc_opt_s opt_cfg;
	int err_total = 0;
	int samples_checked = 0;
	int strobes = 0;
	int rd_pulses = 0;
	int k;
	logic [2:0] st_kind;
	logic [15:0] st_addr, rd_addr;
	logic st_info;
	logic [7:0] st_wdata;

	always #2 aclk = ~aclk;

	fpc_flash_ctl DUT (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .dbg_wr_valid(dbg_wr_valid), .dbg_wr_index(dbg_wr_index),
		.dbg_wr_data(dbg_wr_data), .dbg_wr_ready(dbg_wr_ready), .flash_req(flash_req),
		.flash_rdata(flash_rdata), .stop_recover(stop_recover), .opt_cfg(opt_cfg),
		.cpu_reset_n(cpu_reset_n));

	// strobes are one-cycle pulses, so they are latched here rather than polled
	always @(posedge aclk) begin
		if (flash_req.prog || flash_req.page_erase || flash_req.mass_erase) begin
			strobes <= strobes + 1;
			st_kind <= {flash_req.prog, flash_req.page_erase, flash_req.mass_erase};
			st_addr <= flash_req.addr;
			st_info <= flash_req.info_sel;
			st_wdata <= flash_req.wdata;
		end
		if (flash_req.rd) begin
			rd_pulses <= rd_pulses + 1;
			rd_addr <= flash_req.addr;
		end
	end

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic timed_out();
		err_total++;
		$display("wrong value %s expected %s seen %s", "handshake", "answer", "none");
		print_verdict();
	endtask

	task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic check_resp(input string what, input logic [1:0] exp, input logic [1:0] got);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	// handshakes are judged on values settled at the falling edge, acted on at the rising one
	task automatic axi_write(input logic [13:0] idx, input logic [31:0] d, input logic [1:0] er);
		int n;
		logic aw_t, w_t, b_t;
		logic [1:0] r;
		@(posedge aclk);
		s_axi_awaddr <= {idx, 2'b00};
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(negedge aclk);
			aw_t = s_axi_awvalid && s_axi_awready;
			w_t = s_axi_wvalid && s_axi_wready;
			b_t = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge aclk);
			if (aw_t) s_axi_awvalid <= 1'b0;
			if (w_t) s_axi_wvalid <= 1'b0;
			if (b_t) begin
				s_axi_bready <= 1'b0;
				break;
			end
		end
		if (n == 100) timed_out();
		check_resp("write response", er, r);
	endtask

	task automatic axi_read(input logic [13:0] idx, input logic [1:0] er);
		int n;
		logic ar_t, r_t;
		logic [1:0] r;
		@(posedge aclk);
		s_axi_araddr <= {idx, 2'b00};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(negedge aclk);
			ar_t = s_axi_arvalid && s_axi_arready;
			r_t = s_axi_rvalid;
			r = s_axi_rresp;
			rd_word = s_axi_rdata;
			@(posedge aclk);
			if (ar_t) s_axi_arvalid <= 1'b0;
			if (r_t) begin
				s_axi_rready <= 1'b0;
				break;
			end
		end
		if (n == 100) timed_out();
		check_resp("read response", er, r);
	endtask

	task automatic expect_reg(input string what, input logic [13:0] idx, input logic [7:0] mask,
			input logic [7:0] exp);
		axi_read(idx, fpc_pkg::RESP_OKAY);
		check_word(what, {24'h0, exp & mask}, rd_word & {24'hff_ffff, mask});
	endtask

	task automatic dbg_write(input logic [13:0] idx, input logic [31:0] d);
		int n;
		logic t;
		@(posedge aclk);
		dbg_wr_valid <= 1'b1;
		dbg_wr_index <= idx;
		dbg_wr_data <= d;
		for (n = 0; n < 100; n++) begin
			@(negedge aclk);
			t = dbg_wr_ready;
			@(posedge aclk);
			if (t) begin
				dbg_wr_valid <= 1'b0;
				break;
			end
		end
		if (n == 100) timed_out();
	endtask

	task automatic ctl(input logic [7:0] cmd);
		axi_write(fpc_pkg::IDX_CTL, {24'h0, cmd}, fpc_pkg::RESP_OKAY);
	endtask

	task automatic unlock(input logic [7:0] page);
		ctl(fpc_pkg::CMD_UNLOCK1);
		expect_reg("state first", fpc_pkg::IDX_CTL, 8'h3f, {2'b0, fpc_pkg::ST_FIRST});
		ctl(fpc_pkg::CMD_UNLOCK2);
		expect_reg("state second", fpc_pkg::IDX_CTL, 8'h3f, {2'b0, fpc_pkg::ST_SECOND});
		axi_write(fpc_pkg::IDX_PAGE, {24'h0, page}, fpc_pkg::RESP_OKAY);
		expect_reg("state open", fpc_pkg::IDX_CTL, 8'h3f, {2'b0, fpc_pkg::ST_UNLOCKED});
	endtask

	// long operations are polled over the bus; 300 reads cover the longest erase
	task automatic wait_state(input logic [5:0] st);
		for (k = 0; k < 300; k++) begin
			axi_read(fpc_pkg::IDX_CTL, fpc_pkg::RESP_OKAY);
			if (rd_word[5:0] === st) break;
		end
		if (k == 300) timed_out();
	endtask

	task automatic wait_cpu();
		for (k = 0; k < 50; k++) begin
			@(negedge aclk);
			if (cpu_reset_n === 1'b1) break;
		end
		if (k == 50) timed_out();
	endtask

	initial begin
		repeat (5) @(posedge aclk);
		@(negedge aclk);
		check_word("options in reset", 32'hff, {24'h0, opt_cfg});
		check_word("cpu hold", 32'h0, {31'h0, cpu_reset_n});
		@(posedge aclk);
		aresetn <= 1'b1;
		wait_cpu();
		check_word("options loaded", 32'h5a, {24'h0, opt_cfg});
		check_word("option address", {16'h0, fpc_pkg::OPT_ADDR}, {16'h0, rd_addr});
		$display("test option load done");

		expect_reg("state reset", fpc_pkg::IDX_CTL, 8'h3f, {2'b0, fpc_pkg::ST_LOCKED});
		expect_reg("page reset", fpc_pkg::IDX_PAGE, 8'hff, fpc_pkg::PAGE_SEL_RESET);
		ctl(fpc_pkg::CMD_UNLOCK2);
		expect_reg("state misorder", fpc_pkg::IDX_CTL, 8'h3f, {2'b0, fpc_pkg::ST_LOCKED});
		ctl(fpc_pkg::CMD_UNLOCK1);
		ctl(fpc_pkg::CMD_SPR_SEL);
		expect_reg("state bad code", fpc_pkg::IDX_CTL, 8'h3f, {2'b0, fpc_pkg::ST_LOCKED});
		axi_write(14'h0100, 32'h0000_00aa, fpc_pkg::RESP_SLVERR);
		axi_read(14'h0100, fpc_pkg::RESP_SLVERR);
		check_word("unmapped data", 32'h0, rd_word);
		$display("test lock sequence done");

		unlock(8'h25);
		expect_reg("page readback", fpc_pkg::IDX_PAGE, 8'hff, 8'h25);
		ctl(fpc_pkg::CMD_SPR_SEL);
		expect_reg("state protect", fpc_pkg::IDX_CTL, 8'h3f, {2'b0, fpc_pkg::ST_SPR});
		expect_reg("protect shown", fpc_pkg::IDX_PAGE, 8'hff, fpc_pkg::SPR_RESET);
		axi_write(fpc_pkg::IDX_PAGE, 32'h0, fpc_pkg::RESP_OKAY);
		expect_reg("page kept", fpc_pkg::IDX_PAGE, 8'hff, 8'h25);
		ctl(fpc_pkg::CMD_PAGE_ERASE);
		expect_reg("erase busy", fpc_pkg::IDX_CTL, 8'h38, {2'b0, fpc_pkg::ST_PERASE});
		check_word("erase strobe", 32'h2, {29'h0, st_kind});
		check_word("erase page", 32'h25, {25'h0, st_addr[15:9]});
		wait_state(fpc_pkg::ST_LOCKED);
		$display("test page erase done");

		unlock(8'hff);
		axi_write(fpc_pkg::IDX_PADDR, 32'h0000_01a5, fpc_pkg::RESP_OKAY);
		axi_write(fpc_pkg::IDX_PDATA, 32'h0000_003c, fpc_pkg::RESP_OKAY);
		expect_reg("program busy", fpc_pkg::IDX_CTL, 8'h38, {2'b0, fpc_pkg::ST_PROG});
		check_word("program strobe", 32'h4, {29'h0, st_kind});
		check_word("program address", 32'hffa5, {16'h0, st_addr});
		check_word("info select", 32'h1, {31'h0, st_info});
		check_word("program data", 32'h3c, {24'h0, st_wdata});
		wait_state(fpc_pkg::ST_UNLOCKED);
		ctl(fpc_pkg::CMD_MASS_ERASE);
		expect_reg("mass busy", fpc_pkg::IDX_CTL, 8'h38, {2'b0, fpc_pkg::ST_MERASE});
		check_word("mass strobe", 32'h1, {29'h0, st_kind});
		wait_state(fpc_pkg::ST_LOCKED);
		$display("test program and mass erase done");

		dbg_write(fpc_pkg::IDX_CTL, {24'h0, fpc_pkg::CMD_UNLOCK1});
		dbg_write(fpc_pkg::IDX_CTL, {24'h0, fpc_pkg::CMD_UNLOCK2});
		dbg_write(fpc_pkg::IDX_PAGE, 32'h0000_0030);
		expect_reg("debug unlock", fpc_pkg::IDX_CTL, 8'h3f, {2'b0, fpc_pkg::ST_UNLOCKED});
		dbg_write(fpc_pkg::IDX_CTL, {24'h0, fpc_pkg::CMD_PAGE_ERASE});
		expect_reg("debug erase", fpc_pkg::IDX_CTL, 8'h38, {2'b0, fpc_pkg::ST_PERASE});
		check_word("debug page", 32'h30, {25'h0, st_addr[15:9]});
		wait_state(fpc_pkg::ST_LOCKED);
		$display("test debug port done");

		unlock(8'h10);
		ctl(fpc_pkg::CMD_SPR_SEL);
		axi_write(fpc_pkg::IDX_PAGE, 32'h0000_0002, fpc_pkg::RESP_OKAY);
		expect_reg("protect set", fpc_pkg::IDX_CTL, 8'h3f, {2'b0, fpc_pkg::ST_UNLOCKED});
		k = strobes;
		ctl(fpc_pkg::CMD_PAGE_ERASE);
		expect_reg("protected relock", fpc_pkg::IDX_CTL, 8'h3f, {2'b0, fpc_pkg::ST_LOCKED});
		check_word("no strobe", k, strobes);
		$display("test sector protect done");

		flash_rdata <= 8'ha3;
		repeat (10) @(posedge aclk);
		check_word("options held", 32'h5a, {24'h0, opt_cfg});
		stop_recover <= 1'b1;
		@(posedge aclk);
		stop_recover <= 1'b0;
		repeat (2) @(posedge aclk);
		wait_cpu();
		check_word("options reloaded", 32'ha3, {24'h0, opt_cfg});
		check_word("option fetches", 32'h2, rd_pulses);
		$display("test option reload done");
		print_verdict();
	end
endmodule
`default_nettype wire
